// >>> hdl/rcpf_pkg.sv
package rcpf_pkg;

	// Analog levels in tenths of a millivolt, kept for reference; the selection logic does not use them.
	localparam int OC1_STARTUP_MV_X10 = 5500;
	localparam int OC1_BURST_MV_X10 = 7500;
	localparam int OC1_NORM_MV_X10 = 4275;

	localparam int CLK_HZ = 50_000_000;
	localparam int SS_STEP_US = 512;
	localparam int SS_STEP_CYCLES = (SS_STEP_US * (CLK_HZ / 1_000_000));
	localparam int RESTART_BREAK_MS = 1000;
	localparam int RESTART_BREAK_CYCLES = RESTART_BREAK_MS * (CLK_HZ / 1000);
	localparam int OLP_QUAL_CYCLES = 1_000_000;
	localparam int OVERCURRENT_FAULT_LIMIT = 8;

	// Register offsets on the plain port.
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_STATUS = 4'h1;
	localparam logic [3:0] REG_IRQ_STAT = 4'h2;
	localparam logic [3:0] REG_IRQ_MASK = 4'h3;
	localparam logic [3:0] REG_OLP_THR = 4'h4;
	localparam logic [3:0] REG_OC_FREQ = 4'h5;
	localparam logic [3:0] REG_ACC_LOG2 = 4'h6;
	localparam logic [3:0] REG_FREQ = 4'h7;

	localparam logic [15:0] OLP_THR_RESET = 16'hC000;
	localparam logic [15:0] OC_FREQ_RESET = 16'hF000;
	localparam logic [15:0] FREQ_MAX = 16'hFFFF;
	localparam logic [15:0] SS_STEP_INIT = 16'h0800;
	localparam logic [15:0] SS_STEP_MIN = 16'h0010;
	localparam logic [15:0] OC_STEP_DOWN = 16'h0040;
	localparam logic [3:0] ACC_LOG2_RESET = 4'h4;

	// Interrupt status bit positions.
	localparam int IRQ_OPEN_LOOP = 0;
	localparam int IRQ_OVERLOAD = 1;
	localparam int IRQ_OC1_LIMIT = 2;
	localparam int IRQ_OC2 = 3;
	localparam int IRQ_CCM = 4;
	localparam int IRQ_WIDTH = 5;

	typedef enum logic [1:0] {OC1_SEL_STARTUP, OC1_SEL_BURST, OC1_SEL_NORM,
		OC1_SEL_NONE} rcpf_oc1_sel_type;

	typedef enum {HB_OFF, HB_SOFTSTART, HB_NORMAL, HB_RESTART} rcpf_hb_state_type;
	typedef enum {PF_OFF, PF_OLCHECK, PF_SOFTSTART, PF_NORMAL, PF_PAUSE,
		PF_RESTART} rcpf_pf_state_type;
	typedef enum {SYS_INIT, SYS_RUN} rcpf_sys_state_type;

	typedef struct packed {
		logic [3:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
	} rcpf_bus_req_type;

	typedef struct packed {
		logic bus_open_loop;
		logic bus_near_rated;
		logic bus_at_rated;
		logic bus_overvoltage_soft;
		logic bus_overvoltage_hard;
		logic continuous_conduction;
	} rcpf_pfc_sense_type;

endpackage

// >>> hdl/rcpf_top.sv
`timescale 1ns/100ps
`default_nettype none
module rcpf_top
	import rcpf_pkg::*;
#(
	parameter int RESTART_CYCLES = RESTART_BREAK_CYCLES,
	parameter int QUAL_CYCLES = OLP_QUAL_CYCLES,
	parameter int STEP_CYCLES = SS_STEP_CYCLES,
	parameter int FAULT_LIMIT = OVERCURRENT_FAULT_LIMIT
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic clk_en,
	input wire logic supply_good,
	input wire logic burst_exit,
	input wire logic hb_cycle_end,
	input wire logic fb_sample_valid,
	input wire logic [15:0] hb_feedback_voltage,
	input wire logic [15:0] vco_freq,
	input wire logic oc1_cmp_startup,
	input wire logic oc1_cmp_burst,
	input wire logic oc1_cmp_norm,
	input wire logic hb_overcurrent_level2,
	input wire rcpf_pfc_sense_type pfc_sense,
	input wire logic pfc_gate_req,
	input wire rcpf_bus_req_type bus_req,
	output logic [15:0] rdata,
	output logic irq,
	output logic pfc_gate,
	output logic pfc_enabled,
	output logic pfc_integ_limit,
	output logic hb_gate_en,
	output logic [15:0] hb_freq,
	output logic hb_freq_override,
	output logic [1:0] oc1_threshold_sel,
	output logic setup_load
);

	// The episode counter is four bits wide and must reach one past the
	// limit without wrapping; every cycle count needs at least one cycle.
	if (FAULT_LIMIT < 1 || FAULT_LIMIT > 14 || STEP_CYCLES < 1 ||
		QUAL_CYCLES < 1 || RESTART_CYCLES < 1) begin : g_param_check
		$error("rcpf_top: parameter out of range");
	end

	function automatic logic [15:0] sat_sub(input logic [15:0] a,
		input logic [15:0] b);
		sat_sub = (a > b) ? a - b : 16'h0000;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Registers.

	logic [1:0] ctrl;
	logic [IRQ_WIDTH-1:0] irq_stat;
	logic [IRQ_WIDTH-1:0] irq_mask;
	logic [15:0] olp_thr;
	logic [15:0] oc_freq;
	logic [3:0] acc_log2;
	logic [IRQ_WIDTH-1:0] irq_event;
	rcpf_hb_state_type hb_state;
	rcpf_pf_state_type pf_state;
	rcpf_sys_state_type sys_state;
	logic oc_active;
	logic [3:0] oc_count;

	wire wr_ctrl = bus_req.wr && bus_req.addr == REG_CTRL;
	wire wr_clr = bus_req.wr && bus_req.addr == REG_IRQ_STAT;
	wire wr_mask = bus_req.wr && bus_req.addr == REG_IRQ_MASK;
	wire wr_thr = bus_req.wr && bus_req.addr == REG_OLP_THR;
	wire wr_ocf = bus_req.wr && bus_req.addr == REG_OC_FREQ;
	wire wr_acc = bus_req.wr && bus_req.addr == REG_ACC_LOG2;
	wire [15:0] status_word = {8'h00, oc_active, hb_overcurrent_level2,
		2'(hb_state), 1'b0, 3'(pf_state)};
	// An event in the same cycle as a clear wins, so no event is lost.
	wire [IRQ_WIDTH-1:0] next_irq_stat =
		(irq_stat & ~(wr_clr ? bus_req.wdata[IRQ_WIDTH-1:0] : '0)) | irq_event;
	logic [15:0] next_rdata;
	always_comb begin
		case (bus_req.addr)
		REG_CTRL: next_rdata = {14'h0000, ctrl};
		REG_STATUS: next_rdata = status_word;
		REG_IRQ_STAT: next_rdata = 16'(irq_stat);
		REG_IRQ_MASK: next_rdata = 16'(irq_mask);
		REG_OLP_THR: next_rdata = olp_thr;
		REG_OC_FREQ: next_rdata = oc_freq;
		REG_ACC_LOG2: next_rdata = {12'h000, acc_log2};
		REG_FREQ: next_rdata = hb_freq;
		default: next_rdata = 16'h0000;
		endcase
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl <= 2'h0;
			irq_stat <= '0;
			irq_mask <= '0;
			olp_thr <= OLP_THR_RESET;
			oc_freq <= OC_FREQ_RESET;
			acc_log2 <= ACC_LOG2_RESET;
			rdata <= 16'h0000;
		end else if (clk_en) begin
			irq_stat <= next_irq_stat;
			rdata <= bus_req.rd ? next_rdata : 16'h0000;
			if (wr_ctrl)
				ctrl <= bus_req.wdata[1:0];
			if (wr_mask)
				irq_mask <= bus_req.wdata[IRQ_WIDTH-1:0];
			if (wr_thr)
				olp_thr <= bus_req.wdata;
			if (wr_ocf)
				oc_freq <= bus_req.wdata;
			if (wr_acc)
				acc_log2 <= bus_req.wdata[3:0];
		end
	end
	assign irq = |(irq_stat & irq_mask);

	////////////////////////////////////////////////////////////////////////
	// Initialisation and system auto-restart.

	logic hb_trip;
	logic sys_restart;
	logic hb_break_done;
	logic [31:0] hb_break_cnt;
	logic [31:0] pf_break_cnt;
	wire pfc_ccm_trip = pf_state == PF_NORMAL && pfc_sense.continuous_conduction;
	// Setup values are loaded for as long as init lasts, from reset until supply_good
	// is seen high; both stages may only be enabled once the run state has been reached.
	assign setup_load = sys_state == SYS_INIT;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			sys_state <= SYS_INIT;
		else if (clk_en) begin
			if (!supply_good)
				sys_state <= SYS_INIT;
			else
				sys_state <= SYS_RUN;
		end
	end
	wire run = sys_state == SYS_RUN;

	////////////////////////////////////////////////////////////////////////
	// Half-bridge: softstart stepping, averaging and protections.

	logic [15:0] ss_step;
	logic [31:0] step_cnt;
	// The window holds up to 2^15 samples, so the sum and the sample
	// count are sized for the largest setting of the window register.
	logic [30:0] acc_sum;
	logic [14:0] acc_n;
	logic [15:0] fb_avg;
	logic [31:0] qual_cnt;
	// Leaving burst mode takes precedence; the normal level never applies
	// in softstart or while burst mode is being left.
	wire oc1_sel_startup = hb_state == HB_SOFTSTART && !burst_exit;
	wire oc1_sel_burst = burst_exit;
	wire oc1_sel_norm = hb_state == HB_NORMAL && !burst_exit;
	assign oc1_threshold_sel = oc1_sel_burst ? 2'(OC1_SEL_BURST) :
		oc1_sel_startup ? 2'(OC1_SEL_STARTUP) :
		oc1_sel_norm ? 2'(OC1_SEL_NORM) : 2'(OC1_SEL_NONE);
	wire oc1_hit = (oc1_sel_burst && oc1_cmp_burst) ||
		(oc1_sel_startup && oc1_cmp_startup) ||
		(oc1_sel_norm && oc1_cmp_norm);
	wire oc1_event = hb_cycle_end && oc1_hit;
	wire oc1_limit = oc1_event && oc_count >= 4'(FAULT_LIMIT);
	wire avg_high = fb_avg > olp_thr;
	wire qual_done = qual_cnt >= 32'(QUAL_CYCLES - 1);
	// One trip serves open loop and overload alike; which flag is raised
	// depends on whether an overcurrent episode is in progress.
	wire olp_trip = hb_state == HB_NORMAL && avg_high && qual_done;
	wire oc2_trip = run && hb_overcurrent_level2;
	// Any of the three trips stops both converters at once.
	assign sys_restart = oc2_trip || oc1_limit || olp_trip;
	assign hb_trip = sys_restart;
	assign hb_break_done = hb_break_cnt >= 32'(RESTART_CYCLES - 1);
	wire [15:0] next_freq_ss = sat_sub(hb_freq, ss_step);
	wire [15:0] next_freq_oc = sat_sub(hb_freq, OC_STEP_DOWN);
	wire [30:0] next_acc = acc_sum + 31'(hb_feedback_voltage);
	wire [14:0] acc_last = 15'((32'd1 << acc_log2) - 32'd1);

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			hb_state <= HB_OFF;
			hb_freq <= FREQ_MAX;
			ss_step <= SS_STEP_INIT;
			step_cnt <= '0;
			hb_break_cnt <= '0;
		end else if (clk_en) begin
			case (hb_state)
			HB_OFF: begin
				hb_freq <= FREQ_MAX;
				hb_break_cnt <= '0;
				ss_step <= SS_STEP_INIT;
				step_cnt <= '0;
				if (run && ctrl[0] == 1'b0)
					hb_state <= HB_SOFTSTART;
			end
			HB_SOFTSTART: begin
				if (hb_trip)
					hb_state <= HB_RESTART;
				else if (oc_active)
					hb_freq <= oc_freq;
				else if (vco_freq >= hb_freq)
					hb_state <= HB_NORMAL;
				else if (step_cnt >= 32'(STEP_CYCLES - 1)) begin
					step_cnt <= '0;
					hb_freq <= next_freq_ss;
					if (ss_step > SS_STEP_MIN)
						ss_step <= ss_step >> 1;
				end else
					step_cnt <= step_cnt + 32'd1;
			end
			HB_NORMAL: begin
				if (hb_trip)
					hb_state <= HB_RESTART;
				else if (oc1_event)
					hb_freq <= oc_freq;
				else if (oc_active)
					hb_freq <= next_freq_oc;
				else
					hb_freq <= vco_freq;
			end
			HB_RESTART: begin
				hb_freq <= FREQ_MAX;
				ss_step <= SS_STEP_INIT;
				step_cnt <= '0;
				hb_break_cnt <= hb_break_cnt + 32'd1;
				if (hb_break_done) begin
					hb_break_cnt <= '0;
					hb_state <= HB_SOFTSTART;
				end
			end
			default: hb_state <= HB_OFF;
			endcase
			// A supply drop parks the bridge in the same cycle that init is
			// entered, so init never sees the gates enabled.
			if (!run || !supply_good) begin
				hb_state <= HB_OFF;
				hb_freq <= FREQ_MAX;
			end
		end
	end
	assign hb_gate_en = hb_state == HB_SOFTSTART || hb_state == HB_NORMAL;
	assign hb_freq_override = oc_active;

	// Every clean cycle end clears the episode count, but it ends an episode only once
	// vco_freq is above hb_freq or the bridge is not in HB_NORMAL, so only unbroken runs of episodes reach the limit.

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			oc_active <= 1'b0;
			oc_count <= 4'h0;
		end else if (clk_en) begin
			if (!hb_gate_en) begin
				oc_active <= 1'b0;
				oc_count <= 4'h0;
			end else if (oc1_event) begin
				oc_active <= 1'b1;
				oc_count <= oc_count + 4'h1;
			end else if (hb_cycle_end) begin
				oc_count <= 4'h0;
				if (oc_active && (vco_freq > hb_freq || hb_state != HB_NORMAL))
					oc_active <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			acc_sum <= '0;
			acc_n <= '0;
			fb_avg <= 16'h0000;
			qual_cnt <= '0;
		end else if (clk_en) begin
			if (hb_state != HB_NORMAL) begin
				acc_sum <= '0;
				acc_n <= '0;
				fb_avg <= 16'h0000;
				qual_cnt <= '0;
			end else begin
				if (fb_sample_valid) begin
					if (acc_n == acc_last) begin
						fb_avg <= 16'(next_acc >> acc_log2);
						acc_sum <= '0;
						acc_n <= '0;
					end else begin
						acc_sum <= next_acc;
						acc_n <= acc_n + 15'h0001;
					end
				end
				if (!avg_high)
					qual_cnt <= '0;
				else if (!qual_done)
					qual_cnt <= qual_cnt + 32'd1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Power-factor stage flow.

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pf_state <= PF_OFF;
			pf_break_cnt <= '0;
		end else if (clk_en) begin
			case (pf_state)
			PF_OFF: begin
				pf_break_cnt <= '0;
				if (run && ctrl[1] == 1'b0)
					pf_state <= PF_OLCHECK;
			end
			PF_OLCHECK:
				if (!pfc_sense.bus_open_loop)
					pf_state <= PF_SOFTSTART;
			PF_SOFTSTART:
				if (pfc_sense.bus_near_rated)
					pf_state <= PF_NORMAL;
			PF_NORMAL:
				if (pfc_ccm_trip)
					pf_state <= PF_RESTART;
				else if (pfc_sense.bus_overvoltage_soft ||
					pfc_sense.bus_overvoltage_hard)
					pf_state <= PF_PAUSE;
			PF_PAUSE:
				if (pfc_sense.bus_at_rated)
					pf_state <= PF_NORMAL;
			PF_RESTART: begin
				pf_break_cnt <= pf_break_cnt + 32'd1;
				if (pf_break_cnt >= 32'(RESTART_CYCLES - 1)) begin
					pf_break_cnt <= '0;
					pf_state <= PF_SOFTSTART;
				end
			end
			default: pf_state <= PF_OFF;
			endcase
			// A stage that software holds off stays off through a restart.
			if (!run || !supply_good)
				pf_state <= PF_OFF;
			else if (sys_restart && pf_state != PF_OFF)
				pf_state <= PF_RESTART;
		end
	end
	assign pfc_enabled = pf_state != PF_OFF;
	assign pfc_integ_limit = pf_state == PF_SOFTSTART;
	assign pfc_gate = (pf_state == PF_SOFTSTART || pf_state == PF_NORMAL) &&
		pfc_gate_req;

	assign irq_event = {pfc_ccm_trip, oc2_trip, oc1_limit,
		olp_trip && oc_active, olp_trip && !oc_active};

endmodule // rcpf_top
`default_nettype wire

// >>> tb/rcpf_chk_sva.sv
`timescale 1ns/100ps
`default_nettype none
module rcpf_chk import rcpf_pkg::*; (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic burst_exit,
	input wire logic hb_overcurrent_level2,
	input wire rcpf_bus_req_type bus_req,
	input wire logic [15:0] rdata,
	input wire logic pfc_gate,
	input wire logic pfc_enabled,
	input wire logic pfc_integ_limit,
	input wire logic hb_gate_en,
	input wire logic [15:0] hb_freq,
	input wire logic [1:0] oc1_threshold_sel,
	input wire logic setup_load
);
default clocking cb @(posedge clk); endclocking
default disable iff (!rst_b);
////////////////////////////////////////////////////////////////
a_pfc_gate_off: assert property (!pfc_enabled |-> !pfc_gate)
	else $error("pfc gate while off");
a_level2_stop: assert property (hb_overcurrent_level2 && hb_gate_en
	|=> !hb_gate_en [*8]) else $error("level2 did not stop");
a_init_idle: assert property (setup_load |-> !hb_gate_en && !pfc_enabled)
	else $error("stage on during init");
a_off_sel: assert property (!hb_gate_en |-> oc1_threshold_sel != 2'h2)
	else $error("normal level while off");
a_burst_sel: assert property (burst_exit |-> oc1_threshold_sel != 2'h2)
	else $error("normal level in burst");
a_integ_en: assert property (pfc_integ_limit |-> pfc_enabled)
	else $error("limit while pfc off");
a_rdata_idle: assert property (!$past(bus_req.rd) |-> rdata == 16'h0000)
	else $error("read data without read");
a_freq_init: assert property (setup_load |-> hb_freq == FREQ_MAX)
	else $error("start freq not max");
c_restart: cover property ($fell(hb_gate_en));
c_integ: cover property (pfc_integ_limit);
c_burst: cover property (oc1_threshold_sel == 2'h1);
endmodule // rcpf_chk
bind rcpf_top rcpf_chk chk (.clk(clk), .rst_b(rst_b),
	.burst_exit(burst_exit), .hb_overcurrent_level2(hb_overcurrent_level2),
	.bus_req(bus_req), .rdata(rdata), .pfc_gate(pfc_gate),
	.pfc_enabled(pfc_enabled), .pfc_integ_limit(pfc_integ_limit),
	.hb_gate_en(hb_gate_en), .hb_freq(hb_freq),
	.oc1_threshold_sel(oc1_threshold_sel), .setup_load(setup_load));
`default_nettype wire

// >>> tb/rcpf_top_tb.sv
`timescale 1ns/100ps
`default_nettype none
`define WAIT(c) for (i = 0; i < 400 && !(c); i++) @(posedge clk) #1; \
	if (!(c)) begin n_fail++; results(); end
module rcpf_top_tb import rcpf_pkg::*;;
logic clk, rst_b, sup, bex, cend, fbv, oc2, preq, a, ce;
logic [2:0] oc1;
logic [15:0] fb, vco, d, rdata, hfq;
rcpf_pfc_sense_type ps;
rcpf_bus_req_type br;
logic irq, pg, pen, integ, gen, ovr, setup;
logic [1:0] sel;
int n_fail = 0;
int checked = 0;
int i, k;
rcpf_top #(.RESTART_CYCLES(20), .QUAL_CYCLES(10), .STEP_CYCLES(8),
	.FAULT_LIMIT(8)) dut (.clk(clk), .rst_b(rst_b), .clk_en(ce),
	.supply_good(sup), .burst_exit(bex), .hb_cycle_end(cend),
	.fb_sample_valid(fbv), .hb_feedback_voltage(fb), .vco_freq(vco),
	.oc1_cmp_startup(oc1[2]), .oc1_cmp_burst(oc1[1]),
	.oc1_cmp_norm(oc1[0]), .hb_overcurrent_level2(oc2), .pfc_sense(ps),
	.pfc_gate_req(preq), .bus_req(br), .rdata(rdata), .irq(irq),
	.pfc_gate(pg), .pfc_enabled(pen), .pfc_integ_limit(integ),
	.hb_gate_en(gen), .hb_freq(hfq), .hb_freq_override(ovr),
	.oc1_threshold_sel(sel), .setup_load(setup));
initial begin
	clk = 1'b0;
	forever #10 clk = ~clk;
end
////////////////////////////////////////////////////////////////
task results;
	$display("checks %0d failures %0d", checked, n_fail);
	if (n_fail == 0 && checked > 0)
		$display("*** PASS ***");
	else
		$display("*** FAIL ***");
	$finish;
endtask
task chk(input logic [15:0] g, input logic [15:0] e);
	checked++;
	if (g !== e) begin
		n_fail++;
		$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
	end
endtask
task wr(input logic [3:0] ad, input logic [15:0] v);
	@(posedge clk);
	br <= '{ad, v, 1'b1, 1'b0};
	@(posedge clk);
	br.wr <= 1'b0;
endtask
task rd(input logic [3:0] ad);
	@(posedge clk);
	br <= '{ad, 16'h0000, 1'b0, 1'b1};
	@(posedge clk);
	br.rd <= 1'b0;
	#1 d = rdata;
endtask
task cyc(input int n);
	repeat (n) begin
		@(posedge clk);
		cend <= 1'b1;
		@(posedge clk);
		cend <= 1'b0;
	end
endtask
initial begin
	{rst_b, sup, bex, cend, fbv, oc2, preq, oc1, fb, vco} = '0;
	ps = '0;
	br = '0;
	ce = 1'b1;
	repeat (6) @(posedge clk);
	rst_b <= 1'b1;
	#1 chk(setup, 1'b1);
	rd(REG_OLP_THR);
	chk(d, OLP_THR_RESET);
	rd(REG_ACC_LOG2);
	chk(d, 16'(ACC_LOG2_RESET));
	wr(4'hC, 16'h1234);
	rd(4'hC);
	chk(d, 16'h0000);
	wr(REG_CTRL, 16'h0002);
	ps.bus_open_loop <= 1'b1;
	{preq, sup} <= 2'b11;
	`WAIT(hfq !== FREQ_MAX)
	chk(hfq, 16'hF7FF);
	chk(sel, 2'h0);
	chk(gen, 1'b1);
	chk(pg, 1'b0);
	wr(REG_CTRL, 16'h0000);
	`WAIT(pen)
	rd(REG_STATUS);
	chk(d[2:0], 3'h1);
	ps.bus_open_loop <= 1'b0;
	`WAIT(integ)
	chk(pg, 1'b1);
	ps.bus_near_rated <= 1'b1;
	`WAIT(!integ)
	rd(REG_STATUS);
	chk(d[2:0], 3'h3);
	for (k = 1; k < 3; k++) begin
		ps.bus_at_rated <= 1'b0;
		ps[k] <= 1'b1;
		repeat (3) @(posedge clk);
		#1 chk(pg, 1'b0);
		@(posedge clk) ps[k] <= 1'b0;
		ps.bus_at_rated <= 1'b1;
		`WAIT(pg)
	end
	@(posedge clk) ps.continuous_conduction <= 1'b1;
	@(posedge clk) ps.continuous_conduction <= 1'b0;
	#1 chk(pg, 1'b0);
	`WAIT(integ)
	chk(16'(i), 16'h0014);
	$display("test pfc flow done");
	vco <= 16'hFFFF;
	`WAIT(sel == 2'h2)
	@(posedge clk) bex <= 1'b1;
	#1 chk(sel, 2'h1);
	@(posedge clk) bex <= 1'b0;
	oc1 <= 3'b111;
	cyc(1);
	#1 chk(ovr, 1'b1);
	chk(hfq, OC_FREQ_RESET);
	cyc(7);
	oc1 <= 3'b000;
	cyc(1);
	`WAIT(!ovr)
	chk(hfq, 16'hFFFF);
	oc1 <= 3'b111;
	cyc(8);
	chk(gen, 1'b1);
	cyc(1);
	`WAIT(!gen)
	oc1 <= 3'b000;
	rd(REG_IRQ_STAT);
	chk(d[2], 1'b1);
	wr(REG_IRQ_MASK, 16'h0000);
	#1 a = irq;
	wr(REG_IRQ_MASK, 16'h001F);
	#1 chk(a ^ irq, 1'b1);
	wr(REG_IRQ_STAT, 16'h001F);
	rd(REG_IRQ_STAT);
	chk(d, 16'h0000);
	chk(irq, 1'b0);
	$display("test overcurrent done");
	`WAIT(sel == 2'h2)
	@(posedge clk) oc2 <= 1'b1;
	@(posedge clk) #1 chk(gen, 1'b0);
	rd(REG_STATUS);
	chk(d[6], 1'b1);
	oc2 <= 1'b0;
	wr(REG_IRQ_STAT, 16'h001F);
	for (k = 0; k < 2; k++) begin
		`WAIT(sel == 2'h2)
		@(posedge clk) oc1 <= {3{k[0]}};
		cyc(k);
		{fb, fbv} <= {16'hF000, 1'b1};
		`WAIT(!gen)
		rd(REG_IRQ_STAT);
		chk(d[1:0], k ? 2'h2 : 2'h1);
		{fbv, oc1} <= '0;
		wr(REG_IRQ_STAT, 16'h001F);
		`WAIT(gen)
		chk(sel, 2'h0);
	end
	$display("test feedback protection done");
	`WAIT(sel == 2'h2)
	@(posedge clk) {ce, vco} <= {1'b0, 16'h0000};
	repeat (3) @(posedge clk);
	#1 chk(hfq, FREQ_MAX);
	@(posedge clk) ce <= 1'b1;
	@(posedge clk) #1 chk(hfq, 16'h0000);
	$display("test clock enable done");
	results();
end
endmodule // rcpf_top_tb
`default_nettype wire
